/* File: hdl/ser_top.sv */
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Enabled latched event bit drives the group summary bit high.
// - Group summary feeds the condition input of the next level up.
// - Set negative filter bit latches event on condition one-to-zero.
// - Set positive filter bit latches event on condition zero-to-one.
// - Questionable summary sits at status byte bit 3, weight 8.
// - Status byte bit 6 set whenever a service request is issued.
// - Limit subgroup summary sits at questionable bit 9, value 512.
// - Limit event read returns zeros next time unless new edge.
// - Condition part equals live source states, even after event clear.
// - After clear only new transitions latch; steady sources do not.
// - Operation condition bits 16 measuring, 32 waiting, 64 triggered.
// - Finished single acquisition clears measuring, leaving value 96.
// - Event status register read returns contents then clears all.
// - Operation-complete command sets flag once pending work is done.
// - Every event part clears as a side effect of its read.
// - Reading a condition part leaves it unchanged.
module ser_top #(
   parameter int LIM_W = 16
) (
   input  wire logic             clk,          // 20 MHz clock
   input  wire logic             rst,          // Async reset, high
   input  wire logic             hsel,         // AHB select
   input  wire logic [7:0]       haddr,        // AHB address
   input  wire logic [1:0]       htrans,       // AHB transfer type
   input  wire logic             hwrite,       // AHB write
   input  wire logic [2:0]       hsize,        // AHB size
   input  wire logic [31:0]      hwdata,       // AHB write data
   input  wire logic             hready,       // AHB bus ready
   output logic      [31:0]      hrdata,       // AHB read data
   output logic                  hreadyout,    // AHB slave ready
   output logic                  hresp,        // AHB response
   input  wire logic [LIM_W-1:0] limit_src,    // Limit violation pins
   input  wire logic             acq_start,    // Single acquisition start
   input  wire logic             pretrig_done, // Pretrigger time over
   input  wire logic             trig_seen,    // Trigger occurred
   input  wire logic             acq_done,     // Acquisition finished
   input  wire logic             ops_busy,     // Pending operations
   output logic      [6:0]       oper_cond,    // Operation condition
   output logic                  srq_reg,      // Service request
   output logic                  irq_reg       // Interrupt level
);
   import ser_pkg::*;

   // ****************************************
   // Pin synchronisers (3 stages, agree on 2/3)
   // ****************************************
   localparam int NS = LIM_W + 5;
   logic [NS-1:0] pin_raw;
   logic [NS-1:0] s1_reg;
   logic [NS-1:0] s2_reg;
   logic [NS-1:0] s3_reg;
   logic [NS-1:0] pin_reg;
   logic [NS-1:0] pin_next;
   assign pin_raw  = {ops_busy, acq_done, trig_seen, pretrig_done, acq_start, limit_src};
   assign pin_next = (s2_reg == s3_reg) ? s3_reg : pin_reg;
   // Agreement check keeps the first stage private to the chain
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s1_reg  <= '0;
         s2_reg  <= '0;
         s3_reg  <= '0;
         pin_reg <= '0;
      end
      else
      begin
         s1_reg  <= pin_raw;
         s2_reg  <= s1_reg;
         s3_reg  <= s2_reg;
         pin_reg <= pin_next;
      end
   end
   logic [LIM_W-1:0] lim_sync;
   logic             start_s;
   logic             pre_s;
   logic             trig_s;
   logic             done_s;
   logic             busy_s;
   assign lim_sync = pin_reg[LIM_W-1:0];
   assign start_s  = pin_reg[LIM_W];
   assign pre_s    = pin_reg[LIM_W+1];
   assign trig_s   = pin_reg[LIM_W+2];
   assign done_s   = pin_reg[LIM_W+3];
   assign busy_s   = pin_reg[LIM_W+4];

   // ****************************************
   // AHB-Lite slave, zero wait state
   // ****************************************
   logic       ap_valid;
   logic       dp_wr_reg;
   logic       dp_rd_reg;
   logic [7:0] dp_addr_reg;
   assign ap_valid = hsel & htrans[1] & hready;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         dp_wr_reg   <= 1'b0;
         dp_rd_reg   <= 1'b0;
         dp_addr_reg <= 8'h00;
      end
      else
      begin
         dp_wr_reg   <= ap_valid & hwrite;
         dp_rd_reg   <= ap_valid & ~hwrite;
         dp_addr_reg <= ap_valid ? haddr : dp_addr_reg;
      end
   end

   function automatic logic hit_w(input logic [7:0] a, input logic [7:0] off);
      hit_w = (a == off);
   endfunction : hit_w

   // Read-clear pulses fire in the address phase so data is taken before clear
   logic rd_ap;
   logic lim_rd;
   logic ques_rd;
   logic esr_rd;
   logic irq_w;
   assign rd_ap   = ap_valid & ~hwrite;
   assign lim_rd  = rd_ap & hit_w(haddr, SER_OFF_LIM_EVT);
   assign ques_rd = rd_ap & hit_w(haddr, SER_OFF_QUES_EVT);
   assign esr_rd  = rd_ap & hit_w(haddr, SER_OFF_ESR);
   assign irq_w   = dp_wr_reg & hit_w(dp_addr_reg, SER_OFF_IRQ_STAT);

   // ****************************************
   // Software writable registers
   // ****************************************
   logic [LIM_W-1:0] lim_ptr_reg;
   logic [LIM_W-1:0] lim_ntr_reg;
   logic [LIM_W-1:0] lim_ena_reg;
   logic [15:0]      ques_ptr_reg;
   logic [15:0]      ques_ntr_reg;
   logic [15:0]      ques_ena_reg;
   logic [7:0]       sre_reg;
   logic [1:0]       irq_mask_reg;
   logic             opc_arm_reg;
   logic             cls_w;
   logic             opc_w;
   assign cls_w = dp_wr_reg & hit_w(dp_addr_reg, SER_OFF_CMD) & hwdata[SER_CMD_CLS_BIT];
   assign opc_w = dp_wr_reg & hit_w(dp_addr_reg, SER_OFF_CMD) & hwdata[SER_CMD_OPC_BIT];
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         lim_ptr_reg  <= LIM_W'(SER_RST_PTR);
         lim_ntr_reg  <= LIM_W'(SER_RST_NTR);
         lim_ena_reg  <= LIM_W'(SER_RST_ENA);
         ques_ptr_reg <= SER_RST_PTR;
         ques_ntr_reg <= SER_RST_NTR;
         ques_ena_reg <= SER_RST_ENA;
         sre_reg      <= SER_RST_SRE;
         irq_mask_reg <= SER_RST_IRQ;
      end
      else if (dp_wr_reg)
      begin
         if (hit_w(dp_addr_reg, SER_OFF_LIM_PTR))  lim_ptr_reg  <= hwdata[LIM_W-1:0];
         if (hit_w(dp_addr_reg, SER_OFF_LIM_NTR))  lim_ntr_reg  <= hwdata[LIM_W-1:0];
         if (hit_w(dp_addr_reg, SER_OFF_LIM_ENA))  lim_ena_reg  <= hwdata[LIM_W-1:0];
         if (hit_w(dp_addr_reg, SER_OFF_QUES_PTR)) ques_ptr_reg <= hwdata[15:0];
         if (hit_w(dp_addr_reg, SER_OFF_QUES_NTR)) ques_ntr_reg <= hwdata[15:0];
         if (hit_w(dp_addr_reg, SER_OFF_QUES_ENA)) ques_ena_reg <= hwdata[15:0];
         if (hit_w(dp_addr_reg, SER_OFF_SRE))      sre_reg      <= hwdata[7:0];
         if (hit_w(dp_addr_reg, SER_OFF_IRQ_MASK)) irq_mask_reg <= hwdata[1:0];
      end
   end

   // ****************************************
   // Limit group and questionable group
   // ****************************************
   logic [LIM_W-1:0] lim_cond;
   logic [LIM_W-1:0] lim_evt;
   logic             lim_sum;
   logic [15:0]      ques_src;
   logic [15:0]      ques_cond;
   logic [15:0]      ques_evt;
   logic             ques_sum;
   ser_group #(.W(LIM_W)) u_lim (
      .clk     (clk),
      .rst     (rst),
      .cond_in (lim_sync),
      .ptr     (lim_ptr_reg),
      .ntr     (lim_ntr_reg),
      .ena     (lim_ena_reg),
      .rd_clr  (lim_rd),
      .cond_reg(lim_cond),
      .evt_reg (lim_evt),
      .sum_reg (lim_sum)
   );
   // Limit summary becomes questionable condition bit 9
   assign ques_src = 16'(lim_sum) << SER_QUES_LIM_BIT;
   ser_group #(.W(16)) u_ques (
      .clk     (clk),
      .rst     (rst),
      .cond_in (ques_src),
      .ptr     (ques_ptr_reg),
      .ntr     (ques_ntr_reg),
      .ena     (ques_ena_reg),
      .rd_clr  (ques_rd),
      .cond_reg(ques_cond),
      .evt_reg (ques_evt),
      .sum_reg (ques_sum)
   );

   // ****************************************
   // Acquisition state and operation condition
   // ****************************************
   ser_acq_t   acq_reg;
   ser_acq_t   acq_next;
   logic       meas_reg;
   logic       meas_next;
   logic [6:0] oper_next;
   always_comb
   begin
      acq_next  = acq_reg;
      meas_next = meas_reg;
      case (acq_reg)
         SER_ACQ_IDLE: if (start_s) begin acq_next = SER_ACQ_MEAS; meas_next = 1'b1; end
         SER_ACQ_MEAS: if (pre_s) acq_next = SER_ACQ_WAIT;
         SER_ACQ_WAIT: if (trig_s) acq_next = SER_ACQ_TRIG;
         SER_ACQ_TRIG: if (done_s) begin acq_next = SER_ACQ_IDLE; meas_next = 1'b0; end
         default:      acq_next = SER_ACQ_IDLE;
      endcase
   end
   // Wait and triggered stay set after the run ends, so 96 remains visible
   always_comb
   begin
      oper_next = oper_cond;
      oper_next[SER_OPER_MEAS_BIT] = meas_next;
      if (acq_next == SER_ACQ_WAIT) oper_next[SER_OPER_WAIT_BIT] = 1'b1;
      if (acq_next == SER_ACQ_TRIG) oper_next[SER_OPER_TRIG_BIT] = 1'b1;
      if (acq_reg == SER_ACQ_IDLE && start_s)
      begin
         oper_next[SER_OPER_WAIT_BIT] = 1'b0;
         oper_next[SER_OPER_TRIG_BIT] = 1'b0;
      end
   end
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         acq_reg   <= SER_ACQ_IDLE;
         meas_reg  <= 1'b0;
         oper_cond <= 7'h00;
      end
      else
      begin
         acq_reg   <= acq_next;
         meas_reg  <= meas_next;
         oper_cond <= oper_next;
      end
   end

   // ****************************************
   // Event status register, status byte, IRQ
   // ****************************************
   logic [7:0] esr_reg;
   logic [7:0] esr_next;
   logic       opc_done;
   logic [7:0] stb_base;
   logic       srq_next;
   logic [1:0] irq_stat_reg;
   logic [1:0] irq_ev;
   logic [1:0] irq_next;
   // Completion waits for busy to drop; set beats the read clear
   assign opc_done = opc_arm_reg & ~busy_s;
   assign esr_next = (esr_rd | cls_w ? 8'h00 : esr_reg)
                   | (8'(opc_done) << SER_ESR_OPC_BIT);
   assign stb_base = (8'(ques_sum) << SER_STB_QUES_BIT)
                   | (8'(|esr_reg) << SER_STB_ESB_BIT);
   assign srq_next = |(stb_base & sre_reg);
   assign irq_ev   = {opc_done, srq_next & ~srq_reg};
   assign irq_next = (irq_stat_reg & ~(irq_w ? hwdata[1:0] : 2'h0)) | irq_ev;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         esr_reg      <= 8'h00;
         opc_arm_reg  <= 1'b0;
         srq_reg      <= 1'b0;
         irq_stat_reg <= 2'h0;
         irq_reg      <= 1'b0;
      end
      else
      begin
         esr_reg      <= esr_next;
         opc_arm_reg  <= opc_w | (opc_arm_reg & busy_s);
         srq_reg      <= srq_next;
         irq_stat_reg <= irq_next;
         irq_reg      <= |(irq_next & irq_mask_reg);
      end
   end

   // ****************************************
   // Read mux (address phase)
   // ****************************************
   logic [31:0] rd_mux;
   logic [7:0]  stb_val;
   assign stb_val = stb_base | (8'(srq_reg) << SER_STB_RQS_BIT);
   always_comb
   begin
      case (haddr)
         SER_OFF_LIM_COND:  rd_mux = 32'(lim_cond);
         SER_OFF_LIM_EVT:   rd_mux = 32'(lim_evt);
         SER_OFF_LIM_PTR:   rd_mux = 32'(lim_ptr_reg);
         SER_OFF_LIM_NTR:   rd_mux = 32'(lim_ntr_reg);
         SER_OFF_LIM_ENA:   rd_mux = 32'(lim_ena_reg);
         SER_OFF_QUES_COND: rd_mux = 32'(ques_cond);
         SER_OFF_QUES_EVT:  rd_mux = 32'(ques_evt);
         SER_OFF_QUES_PTR:  rd_mux = 32'(ques_ptr_reg);
         SER_OFF_QUES_NTR:  rd_mux = 32'(ques_ntr_reg);
         SER_OFF_QUES_ENA:  rd_mux = 32'(ques_ena_reg);
         SER_OFF_OPER_COND: rd_mux = 32'(oper_cond);
         SER_OFF_STB:       rd_mux = 32'(stb_val);
         SER_OFF_SRE:       rd_mux = 32'(sre_reg);
         SER_OFF_ESR:       rd_mux = 32'(esr_reg);
         SER_OFF_IRQ_STAT:  rd_mux = 32'(irq_stat_reg);
         SER_OFF_IRQ_MASK:  rd_mux = 32'(irq_mask_reg);
         default:           rd_mux = 32'h0000_0000;
      endcase
   end
   // Read data is captured at the address-phase edge, the same edge that
   // fires the read-clear, so the value returned is the one before clearing.
   // Limitation: a write still in its data phase lands one edge too late for
   // a read whose address phase overlaps it.
   logic [31:0] rd_hold_reg;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rd_hold_reg <= 32'h0000_0000;
      else if (rd_ap)
         rd_hold_reg <= rd_mux;
   end
   assign hrdata    = rd_hold_reg;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   a_ques_stb: assert property (@(posedge clk) disable iff (rst)
      stb_val[SER_STB_QUES_BIT] == ques_sum) else $error("stb bit3");
   a_rqs_stb: assert property (@(posedge clk) disable iff (rst)
      srq_reg |-> stb_val[SER_STB_RQS_BIT]) else $error("stb bit6");
   a_lim_to_ques: assert property (@(posedge clk) disable iff (rst)
      $rose(lim_sum) |=> ques_cond[SER_QUES_LIM_BIT]) else $error("bit9");
   a_esr_clear: assert property (@(posedge clk) disable iff (rst)
      esr_rd && !opc_done |=> esr_reg == 8'h00) else $error("esr kept");
   a_opc_flag: assert property (@(posedge clk) disable iff (rst)
      opc_done |=> esr_reg[SER_ESR_OPC_BIT]) else $error("opc lost");
   a_done_96: assert property (@(posedge clk) disable iff (rst)
      acq_reg == SER_ACQ_TRIG && done_s |=> oper_cond == 7'h60) else $error("not 96");
   c_srq: cover property (@(posedge clk) disable iff (rst) $rose(srq_reg));
   c_opc: cover property (@(posedge clk) disable iff (rst) opc_done);
   c_acq: cover property (@(posedge clk) disable iff (rst) oper_cond == 7'h70);

endmodule : ser_top
`default_nettype wire

/* File: hdl/ser_pkg.sv */
package ser_pkg;

   // ****************************************
   // Register offsets (byte addresses)
   // ****************************************
   localparam logic [7:0] SER_OFF_LIM_COND  = 8'h00;
   localparam logic [7:0] SER_OFF_LIM_EVT   = 8'h04;
   localparam logic [7:0] SER_OFF_LIM_PTR   = 8'h08;
   localparam logic [7:0] SER_OFF_LIM_NTR   = 8'h0c;
   localparam logic [7:0] SER_OFF_LIM_ENA   = 8'h10;
   localparam logic [7:0] SER_OFF_QUES_COND = 8'h14;
   localparam logic [7:0] SER_OFF_QUES_EVT  = 8'h18;
   localparam logic [7:0] SER_OFF_QUES_PTR  = 8'h1c;
   localparam logic [7:0] SER_OFF_QUES_NTR  = 8'h20;
   localparam logic [7:0] SER_OFF_QUES_ENA  = 8'h24;
   localparam logic [7:0] SER_OFF_OPER_COND = 8'h28;
   localparam logic [7:0] SER_OFF_STB       = 8'h2c;
   localparam logic [7:0] SER_OFF_SRE       = 8'h30;
   localparam logic [7:0] SER_OFF_ESR       = 8'h34;
   localparam logic [7:0] SER_OFF_CMD       = 8'h38;
   localparam logic [7:0] SER_OFF_IRQ_STAT  = 8'h3c;
   localparam logic [7:0] SER_OFF_IRQ_MASK  = 8'h40;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int SER_QUES_LIM_BIT  = 9;
   localparam int SER_STB_QUES_BIT  = 3;
   localparam int SER_STB_ESB_BIT   = 5;
   localparam int SER_STB_RQS_BIT   = 6;
   localparam int SER_OPER_MEAS_BIT = 4;
   localparam int SER_OPER_WAIT_BIT = 5;
   localparam int SER_OPER_TRIG_BIT = 6;
   localparam int SER_ESR_OPC_BIT   = 0;
   localparam int SER_CMD_OPC_BIT   = 0;
   localparam int SER_CMD_CLS_BIT   = 1;
   localparam int SER_IRQ_SRQ_BIT   = 0;
   localparam int SER_IRQ_OPC_BIT   = 1;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [15:0] SER_RST_PTR  = 16'hffff;
   localparam logic [15:0] SER_RST_NTR  = 16'h0000;
   localparam logic [15:0] SER_RST_ENA  = 16'h0000;
   localparam logic [7:0]  SER_RST_SRE  = 8'h00;
   localparam logic [1:0]  SER_RST_IRQ  = 2'h0;

   // ****************************************
   // Acquisition states
   // ****************************************
   typedef enum logic [1:0] {
      SER_ACQ_IDLE = 2'b00,
      SER_ACQ_MEAS = 2'b01,
      SER_ACQ_WAIT = 2'b10,
      SER_ACQ_TRIG = 2'b11
   } ser_acq_t;

endpackage : ser_pkg

/* File: hdl/ser_group.sv */
`timescale 1ns/1ns
`default_nettype none
// One condition / transition filter / event / enable register group
module ser_group #(
   parameter int W = 16
) (
   input  wire logic         clk,        // System clock
   input  wire logic         rst,        // Async reset, high
   input  wire logic [W-1:0] cond_in,    // Live source states
   input  wire logic [W-1:0] ptr,        // Rising edge filter
   input  wire logic [W-1:0] ntr,        // Falling edge filter
   input  wire logic [W-1:0] ena,        // Summary enable
   input  wire logic         rd_clr,     // Event read strobe
   output logic      [W-1:0] cond_reg,   // Condition part
   output logic      [W-1:0] evt_reg,    // Event part
   output logic              sum_reg     // Summary bit
);
   import ser_pkg::*;

   // ****************************************
   // Edge detection and latching
   // ****************************************
   logic [W-1:0] hit;
   logic [W-1:0] evt_next;
   // Previous condition is the register itself, so no extra stage
   assign hit = (ptr & cond_in & ~cond_reg)
              | (ntr & ~cond_in & cond_reg);
   // New edge beats read-clear; steady sources never re-latch
   assign evt_next = (rd_clr ? '0 : evt_reg) | hit;

   // Condition mirrors sources, unaffected by reads
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cond_reg <= '0;
         evt_reg  <= '0;
         sum_reg  <= 1'b0;
      end
      else
      begin
         cond_reg <= cond_in;
         evt_reg  <= evt_next;
         sum_reg  <= |(evt_next & ena);
      end
   end

   a_sum_follows: assert property (@(posedge clk) disable iff (rst)
      |(evt_next & ena) |=> sum_reg) else $error("summary mismatch");
   a_rise_latch: assert property (@(posedge clk) disable iff (rst)
      |(ptr & cond_in & ~cond_reg) |=> |evt_reg) else $error("rise lost");
   a_fall_latch: assert property (@(posedge clk) disable iff (rst)
      |(ntr & ~cond_in & cond_reg) |=> |evt_reg) else $error("fall lost");
   a_cond_mirror: assert property (@(posedge clk) disable iff (rst)
      cond_reg == $past(cond_in)) else $error("cond stale");
   a_read_clear: assert property (@(posedge clk) disable iff (rst)
      rd_clr && hit == '0 |=> evt_reg == '0) else $error("no clear");
   a_steady_quiet: assert property (@(posedge clk) disable iff (rst)
      rd_clr && cond_in == cond_reg |=> evt_reg == '0) else $error("relatch");
   a_set_wins: assert property (@(posedge clk) disable iff (rst)
      rd_clr && |hit |=> |evt_reg) else $error("edge lost");

endmodule : ser_group
`default_nettype wire

/* File: sim/ser_top_test.sv */
`timescale 1ns/1ns
`default_nettype none
module ser_top_test;
   import ser_pkg::*;

   // ****************************************
   // Stimulus and observed signals
   // ****************************************
   logic        clk, rst, hsel, hwrite, hreadyout, hresp, srq_reg, irq_reg;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata, rd;
   logic [15:0] limit_src;
   logic        acq_start, pretrig_done, trig_seen, acq_done, ops_busy, irq_a;
   logic [6:0]  oper_cond;
   int          bad_count, n_compared;

   // Single slave, so its ready is the bus ready
   ser_top #(.LIM_W(16)) i_ser_top (
      .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .limit_src(limit_src), .acq_start(acq_start),
      .pretrig_done(pretrig_done), .trig_seen(trig_seen), .acq_done(acq_done),
      .ops_busy(ops_busy), .oper_cond(oper_cond), .srq_reg(srq_reg), .irq_reg(irq_reg));

   // ****************************************
   // Bus and checking tasks
   // ****************************************
   // Address phase held until ready, then data phase; read data taken at the edge that ends it
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel   <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= wr; hsize <= 3'h2;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0; htrans <= 2'b00; hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // Pins pass a three-stage synchroniser, so give each change time to settle
   task automatic pins(input logic [15:0] v);
      @(posedge clk);
      limit_src <= v;
      repeat (12) @(posedge clk);
   endtask : pins

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : final_report

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset_values();
      ahb(0, SER_OFF_LIM_PTR, 0); check("lim_ptr", rd, 32'h0000ffff);
      ahb(0, SER_OFF_LIM_NTR, 0); check("lim_ntr", rd, 32'h0);
      ahb(0, SER_OFF_QUES_ENA, 0); check("ques_ena", rd, 32'h0);
      ahb(0, SER_OFF_SRE, 0); check("sre", rd, 32'h0);
      ahb(1, 8'h7c, 32'hffffffff);
      ahb(0, 8'h7c, 0); check("unmapped", rd, 32'h0);
      check("hresp", {31'h0, hresp}, 32'h0);
      check("hreadyout", {31'h0, hreadyout}, 32'h1);
      $display("test reset_values done");
   endtask : t_reset_values

   // Limit violations climb through the questionable group into the status byte
   task automatic t_limit_chain();
      ahb(1, SER_OFF_LIM_ENA, 32'h0000ffff);
      ahb(1, SER_OFF_QUES_ENA, 32'h00000200);
      ahb(1, SER_OFF_SRE, 32'h00000008);
      pins(16'h0003);
      ahb(0, SER_OFF_STB, 0); check("stb", rd, 32'h48);
      check("srq", {31'h0, srq_reg}, 32'h1);
      ahb(0, SER_OFF_QUES_EVT, 0); check("ques_evt", rd, 32'h200);
      ahb(0, SER_OFF_LIM_EVT, 0); check("lim_evt", rd, 32'h3);
      ahb(0, SER_OFF_LIM_EVT, 0); check("lim_evt_clr", rd, 32'h0);
      ahb(0, SER_OFF_LIM_COND, 0); check("lim_cond", rd, 32'h3);
      ahb(0, SER_OFF_LIM_COND, 0); check("lim_cond_again", rd, 32'h3);
      pins(16'h0007);
      ahb(0, SER_OFF_LIM_EVT, 0); check("lim_evt_new", rd, 32'h4);
      ahb(0, SER_OFF_QUES_EVT, 0); check("ques_evt_new", rd, 32'h200);
      // Falling edges only
      ahb(1, SER_OFF_LIM_PTR, 32'h0);
      ahb(1, SER_OFF_LIM_NTR, 32'h00000001);
      pins(16'h0006);
      ahb(0, SER_OFF_LIM_EVT, 0); check("lim_evt_fall", rd, 32'h1);
      pins(16'h0007);
      ahb(0, SER_OFF_LIM_EVT, 0); check("lim_evt_rise_off", rd, 32'h0);
      // Falling edge reaches the group on the very edge of the read's address phase
      @(posedge clk);
      limit_src <= 16'h0006;
      repeat (3) @(posedge clk);
      ahb(0, SER_OFF_LIM_EVT, 0); check("lim_evt_race", rd, 32'h0);
      ahb(0, SER_OFF_LIM_EVT, 0); check("lim_evt_kept", rd, 32'h1);
      $display("test limit_chain done");
   endtask : t_limit_chain

   // Acquisition progress walks 16, 48, 112 and ends at 96
   task automatic t_acquisition();
      @(posedge clk); acq_start <= 1'b1;
      repeat (3) @(posedge clk); acq_start <= 1'b0;
      repeat (8) @(posedge clk);
      check("oper_meas", {25'h0, oper_cond}, 32'h10);
      pretrig_done <= 1'b1; repeat (10) @(posedge clk);
      check("oper_wait", {25'h0, oper_cond}, 32'h30);
      trig_seen <= 1'b1; repeat (10) @(posedge clk);
      check("oper_trig", {25'h0, oper_cond}, 32'h70);
      acq_done <= 1'b1; repeat (10) @(posedge clk);
      ahb(0, SER_OFF_OPER_COND, 0); check("oper_done", rd, 32'h60);
      pretrig_done <= 1'b0; trig_seen <= 1'b0; acq_done <= 1'b0;
      $display("test acquisition done");
   endtask : t_acquisition

   // Operation complete is polled, read clears it, then the interrupt path
   task automatic t_opc_irq();
      @(posedge clk); ops_busy <= 1'b1;
      ahb(1, SER_OFF_CMD, 32'h2);
      ahb(1, SER_OFF_CMD, 32'h1);
      repeat (10) @(posedge clk);
      ahb(0, SER_OFF_ESR, 0); check("esr_busy", rd, 32'h0);
      ops_busy <= 1'b0; repeat (10) @(posedge clk);
      ahb(0, SER_OFF_ESR, 0); check("esr_opc", rd, 32'h1);
      ahb(0, SER_OFF_ESR, 0); check("esr_clr", rd, 32'h0);
      ahb(0, SER_OFF_IRQ_STAT, 0); check("irq_opc", rd & 32'h2, 32'h2);
      ahb(1, SER_OFF_IRQ_MASK, 32'h3); repeat (3) @(posedge clk); irq_a = irq_reg;
      ahb(1, SER_OFF_IRQ_MASK, 32'h0); repeat (3) @(posedge clk);
      check("irq_mask_effect", {31'h0, irq_a ^ irq_reg}, 32'h1);
      ahb(1, SER_OFF_IRQ_STAT, 32'h3);
      ahb(0, SER_OFF_IRQ_STAT, 0); check("irq_w1c", rd, 32'h0);
      repeat (3) @(posedge clk);
      check("irq_low", {31'h0, irq_reg}, 32'h0);
      $display("test opc_irq done");
   endtask : t_opc_irq

   // ****************************************
   // Clock, reset, sequence and watchdog
   // ****************************************
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   initial
   begin
      rst = 1'b1; hsel = 1'b0; haddr = 8'h0; htrans = 2'b00; hwrite = 1'b0; hsize = 3'h2;
      hwdata = 32'h0; limit_src = 16'h0; acq_start = 1'b0; pretrig_done = 1'b0;
      trig_seen = 1'b0; acq_done = 1'b0; ops_busy = 1'b0; bad_count = 0; n_compared = 0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_reset_values();
      t_limit_chain();
      t_acquisition();
      t_opc_irq();
      final_report();
   end

   // A hang costs far more than the few hundred cycles the tests need
   initial
   begin
      repeat (20000) @(posedge clk);
      bad_count++;
      final_report();
   end
endmodule : ser_top_test
`default_nettype wire
